// File: verilog/adc_port_pkg.sv
// Constants, states and pin layout of the serial result port
package adc_port_pkg;
   localparam int RES_W = 16;
   localparam int MSB = RES_W - 1;
   localparam int FIFO_DEPTH = 8;
   localparam int PIN_N = 5;
   localparam int PAR_LO = 5;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;
   localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
   // Index of each signal in the synchronised input vector
   localparam int IX_SYNC_POL = 0;
   localparam int IX_EDGE_INV = 1;
   localparam int IX_RDC = 2;
   localparam int IX_SERIAL_RESULT_OUT = 3;
   localparam int IX_SCLK = 4;
   localparam int IX_PORT = 5;
   localparam int IX_CSRC = 6;
   localparam int IX_CODE = 7;
   localparam int IX_CS = 8;
   localparam int SYNC_W = 9;
   localparam logic [SYNC_W-1:0] SYNC_INIT = 9'h100;
   // Output enables, low means driven
   localparam logic [PIN_N-1:0] OEN_OFF = 5'h1F;
   localparam logic [PIN_N-1:0] OEN_PAR = 5'h00;
   localparam logic [PIN_N-1:0] OEN_MASTER = 5'h07;
   localparam logic [PIN_N-1:0] OEN_SLAVE = 5'h17;
   // Master result clock timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int MCLK_HALF_NS = 400;
   localparam int MCLK_HALF_CYC = (MCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_W = 8;
   localparam logic [DIV_W-1:0] DIV_RELOAD = DIV_W'(MCLK_HALF_CYC - 1);
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SHIFT = 2'h1,
      ST_END = 2'h3
   } frame_state_t;
endpackage

// File: verilog/stream_if.sv
// Valid/ready word stream, from the result source to the FIFO and from the FIFO to the port
`timescale 1ns/1ps
interface stream_if #(parameter int W = 16) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// File: verilog/input_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module input_sync #(
   parameter int W = 9,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] stage1;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage1 <= INIT;
         sync_out <= INIT;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// File: verilog/result_fifo.sv
// Result word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module result_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rstn,
   stream_if.snk fill,
   stream_if.src drain
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic in_ready;

   wire push = fill.valid & in_ready;
   wire pop = drain.valid & drain.ready;
   wire [AW-1:0] wr_next = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'h1;
   wire [AW-1:0] rd_next = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'h1;

   assign fill.ready = in_ready;
   assign drain.valid = (count != '0);
   assign drain.data = mem[rd_ptr];
   assign next_count = count + CW'(push) - CW'(pop);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'h1;
      end else begin
         wr_ptr <= push ? wr_next : wr_ptr;
         rd_ptr <= pop ? rd_next : rd_ptr;
         count <= next_count;
         in_ready <= (next_count != CW'(DEPTH));
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= fill.data;
      end
   end
endmodule

// File: verilog/adc_serial_result_port.sv
// Serial and parallel result port with shared pins, master and slave clocking
`timescale 1ns/1ps
module adc_serial_result_port (
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Conversion results from the engine
   input wire logic RESULT_VALID,
   input wire logic [adc_port_pkg::RES_W-1:0] RESULT_DATA,
   output logic RESULT_READY,
   input wire logic CONV_START,
   // Mode pins
   input wire logic PORT_TYPE_SELECT,
   input wire logic CLOCK_SOURCE_SELECT,
   input wire logic OUTPUT_CODING_SELECT,
   input wire logic CHIP_SELECT_N,
   // Shared pins, index 0 is parallel bit five
   input wire logic [adc_port_pkg::PIN_N-1:0] SHARED_PIN_IN,
   output logic [adc_port_pkg::PIN_N-1:0] SHARED_PIN_OUT,
   output logic [adc_port_pkg::PIN_N-1:0] SHARED_PIN_OEN,
   // Frame sync
   output logic FRAME_SYNC
);
   import adc_port_pkg::*;

   localparam int M_END_CYC = 2 * MCLK_HALF_CYC * RES_W + 1;
   localparam int M_END_DLY = M_END_CYC - 2;

   logic [SYNC_W-1:0] s;
   frame_state_t state;
   frame_state_t next_state;
   logic [RES_W-1:0] result_reg;
   logic [RES_W-1:0] sh;
   logic [CNT_W-1:0] cnt;
   logic [DIV_W-1:0] div;
   logic phase;
   logic sclk_prev;
   logic cs_prev;
   logic fresh;
   logic [PIN_N-1:0] next_pin_out;
   logic [PIN_N-1:0] next_pin_oen;
   logic next_sync;

   stream_if #(.W(RES_W)) fill_s ();
   stream_if #(.W(RES_W)) drain_s ();

   input_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
      .clk(CLK),
      .rstn(RSTN),
      .async_in({CHIP_SELECT_N, OUTPUT_CODING_SELECT, CLOCK_SOURCE_SELECT,
                 PORT_TYPE_SELECT, SHARED_PIN_IN}),
      .sync_out(s)
   );

   result_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .rstn(RSTN),
      .fill(fill_s),
      .drain(drain_s)
   );

   assign fill_s.valid = RESULT_VALID;
   assign fill_s.data = RESULT_DATA;
   assign RESULT_READY = fill_s.ready;

   // Mode decode
   wire serial = s[IX_PORT];
   wire master = serial & ~s[IX_CSRC];
   wire slave = serial & s[IX_CSRC];
   wire sync_pol = s[IX_SYNC_POL];
   wire edge_inv = s[IX_EDGE_INV];
   wire read_during_convert = s[IX_RDC];
   wire daisy = s[IX_RDC];
   wire cs_n = s[IX_CS];
   wire ext_sclk = s[IX_SCLK];
   wire idle = (state == ST_IDLE);
   wire shifting = (state == ST_SHIFT);

   // Result coding: MSB inverted when coding select is low
   wire [RES_W-1:0] coded = {result_reg[MSB] ^ ~s[IX_CODE], result_reg[MSB-1:0]};

   // Host clock edges, active edge picked by the invert pin
   wire ext_rise = ~sclk_prev & ext_sclk;
   wire ext_fall = sclk_prev & ~ext_sclk;
   wire ext_active = edge_inv ? ext_fall : ext_rise;
   wire cs_fall = cs_prev & ~cs_n;

   // Internal clock: phase 1 to 0 is the active edge
   wire tick = (div == '0);
   wire m_shift = master & shifting & tick & phase;
   wire s_shift = slave & shifting & ext_active & ~cs_n;
   wire shift_evt = m_shift | s_shift;
   wire last_bit = (cnt == LAST_BIT);

   // Read sequence starts
   wire conv_go = master & read_during_convert & CONV_START;
   wire after_conv = master & ~read_during_convert & fresh;
   wire slave_go = slave & cs_fall;
   wire do_start = idle & (after_conv | conv_go | slave_go);
   wire end_frame = ~serial | (master ? (m_shift & last_bit) : cs_n);

   // Draining stalls while a frame is in progress
   assign drain_s.ready = idle & ~fresh & ~conv_go & ~(slave & ~cs_n);
   wire pop = drain_s.valid & drain_s.ready;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (do_start) begin
               next_state = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (end_frame) begin
               next_state = ST_END;
            end
         end
         ST_END: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state <= ST_IDLE;
         sclk_prev <= 1'h0;
         cs_prev <= 1'h1;
         fresh <= 1'h0;
      end else begin
         state <= next_state;
         sclk_prev <= ext_sclk;
         cs_prev <= cs_n;
         fresh <= pop;
      end
   end

   // Completed results are held here until read
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         result_reg <= '0;
      end else if (pop) begin
         result_reg <= drain_s.data;
      end
   end

   // Shift register, MSB out first, daisy data enters at the bottom
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sh <= '0;
      end else if (do_start) begin
         sh <= coded;
      end else if (shift_evt) begin
         sh <= {sh[MSB-1:0], slave & daisy};
      end
   end

   // Bit counter saturates so a long daisy chain keeps shifting
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cnt <= '0;
      end else if (do_start) begin
         cnt <= '0;
      end else if (shift_evt && cnt != FRAME_BITS) begin
         cnt <= cnt + 1'h1;
      end
   end

   // Half-period divider for the internal result clock
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         div <= DIV_RELOAD;
         phase <= 1'h0;
      end else if (do_start || !shifting) begin
         div <= DIV_RELOAD;
         phase <= 1'h0;
      end else if (master && tick) begin
         div <= DIV_RELOAD;
         phase <= ~phase;
      end else if (master) begin
         div <= div - 1'h1;
      end
   end

   // Pin drive and enable selection
   always_comb begin
      next_pin_out = '0;
      next_pin_oen = OEN_SLAVE;
      if (!serial) begin
         next_pin_out = coded[PAR_LO +: PIN_N];
         next_pin_oen = OEN_PAR;
      end else begin
         next_pin_out[IX_SERIAL_RESULT_OUT] = sh[MSB];
         next_pin_out[IX_SCLK] = master & ~(phase ^ edge_inv);
         next_pin_oen = master ? OEN_MASTER : OEN_SLAVE;
      end
   end

   assign next_sync = (master & shifting) ^ sync_pol;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         SHARED_PIN_OUT <= '0;
         SHARED_PIN_OEN <= OEN_OFF;
         FRAME_SYNC <= 1'h0;
      end else begin
         SHARED_PIN_OUT <= next_pin_out;
         SHARED_PIN_OEN <= next_pin_oen;
         FRAME_SYNC <= next_sync;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   AST_PAR_BITS: assert property (
      !serial |=> (SHARED_PIN_OUT == $past(coded[PAR_LO +: PIN_N])) && (SHARED_PIN_OEN == OEN_PAR))
      else $error("parallel bits not driven from result");

   AST_SYNC_LEVEL: assert property (
      (master && shifting) |=> (FRAME_SYNC == !$past(sync_pol)))
      else $error("frame sync active level wrong");

   AST_SYNC_IDLE: assert property (
      (serial && idle) |=> (FRAME_SYNC == $past(sync_pol)))
      else $error("frame sync active outside frame");

   AST_AFTER_CONV: assert property (
      (do_start && master && !read_during_convert) |-> $past(pop))
      else $error("read-after-convert started without fresh result");

   AST_DURING_CONV: assert property (
      (do_start && master && read_during_convert) |-> CONV_START && !pop)
      else $error("read-during-convert start not tied to conversion");

   AST_DAISY_IN: assert property (
      s_shift |=> (sh[0] == $past(daisy)))
      else $error("daisy bit not shifted in");

   AST_MSB_FIRST: assert property (
      do_start |=> (sh == $past(coded)) ##1 (SHARED_PIN_OUT[IX_SERIAL_RESULT_OUT] == sh[MSB] || !serial))
      else $error("shift register not loaded with coded result");

   AST_CODING: assert property (
      do_start |=> (sh[MSB] == ($past(result_reg[MSB]) ^ !$past(s[IX_CODE]))))
      else $error("MSB coding does not follow coding select");

   AST_BIT_HOLD: assert property (
      (master && shifting && !m_shift && !do_start) |=> $stable(sh))
      else $error("serial bit changed away from active edge");

   AST_ACTIVE_EDGE: assert property (
      m_shift |=> !phase ##1 (SHARED_PIN_OUT[IX_SCLK] == !$past(edge_inv) || !master))
      else $error("shift not on active clock edge");

   AST_CLK_DIR: assert property (
      serial |=> (SHARED_PIN_OEN[IX_SCLK] == $past(slave)))
      else $error("result clock pin direction wrong");

   AST_FRAME_LEN: assert property (
      (do_start && master) ##1 (master && serial)[*2] |-> ##M_END_DLY (state == ST_END))
      else $error("master frame length wrong");

   AST_RESULT_REG: assert property (
      pop |=> (result_reg == $past(drain_s.data)))
      else $error("result register not updated on pop");

   AST_SERIAL_OEN: assert property (
      serial |=> (SHARED_PIN_OEN == ($past(master) ? OEN_MASTER : OEN_SLAVE)))
      else $error("serial pin enables wrong");

   AST_SERIAL_RESULT_OUT_PIN: assert property (
      serial |=> (SHARED_PIN_OUT[IX_SERIAL_RESULT_OUT] == $past(sh[MSB])))
      else $error("serial out pin not fed from shift register MSB");

   AST_SLAVE_HOLD: assert property (
      (slave && shifting && !s_shift) |=> $stable(sh))
      else $error("slave bit changed away from active host edge");

   AST_MCLK_IDLE: assert property (
      (master && idle) |=> (SHARED_PIN_OUT[IX_SCLK] == !$past(edge_inv)))
      else $error("master clock not idling at its active-edge level");

   AST_SLAVE_START: assert property (
      (slave && idle && cs_fall) |=> shifting)
      else $error("slave read not started by chip select");

   AST_SLAVE_END: assert property (
      (slave && shifting && cs_n) |=> (state == ST_END))
      else $error("slave read not ended by chip select release");

   COV_MASTER_FRAME: cover property (master && shifting ##1 state == ST_END);
   COV_SLAVE_DAISY: cover property (s_shift && cnt == FRAME_BITS);
   COV_DURING_CONV: cover property (do_start && conv_go);
   COV_FIFO_FULL: cover property (RESULT_VALID && !RESULT_READY);
endmodule

// File: bench/host_serial_model.sv
// Host serial port model: captures master frames and reads slave frames
`timescale 1ns/1ps
module host_serial_model (
   // Clocking and mode
   input wire logic clk,
   input wire logic en,
   input wire logic pol,
   input wire logic inv,
   // Serial lines
   input wire logic sdata,
   input wire logic mclk,
   input wire logic fsync,
   output logic sclk,
   output logic cs_n
);
   logic [15:0] sh;
   logic [15:0] got_q[$];
   logic d_q;
   logic f_q;
   logic mid;
   int cnt;
   int bad;
   wire act = en && (f_q == !pol);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      cnt = 0;
      bad = 0;
   end
   // Data and sync as they stood before any clock pin change, like a host hold time
   always @(negedge clk) begin
      d_q = sdata;
      f_q = fsync;
   end
   always @(mclk) begin
      if (act && mclk != inv) begin
         sh = {sh[14:0], d_q};
         cnt++;
         if (mid !== d_q) bad++;
      end else if (act) begin
         mid = d_q;
      end
   end
   always @(posedge clk) begin
      if (!act && cnt != 0) begin
         if (cnt != 16) bad++;
         got_q.push_back(sh);
         cnt = 0;
      end
   end
   // Clock is gated by chip select and idles at its inactive level
   task automatic slave_read(input int n, input logic inv_l, output logic [31:0] bits);
      bits = '0;
      sclk = inv_l;
      #400;
      cs_n = 1'b0;
      #1200;
      repeat (n) begin
         bits = {bits[30:0], sdata};
         sclk = !inv_l;
         #400;
         sclk = inv_l;
         #400;
      end
      cs_n = 1'b1;
      #400;
   endtask
endmodule

// File: bench/adc_serial_result_port_tb.sv
// Self-checking bench for the serial and parallel result port
`timescale 1ns/1ps
module adc_serial_result_port_tb;
   import adc_port_pkg::*;
   logic clk, rstn, valid, conv, ser, csrc, coding, pol, inv, aux, ready, fsync, cs_n, sclk;
   logic saw_full, hen;
   logic [RES_W-1:0] data, w;
   logic [PIN_N-1:0] pout, poen, pin, drv;
   logic [31:0] seed, bits;
   logic [RES_W-1:0] exp_q[$];
   int miscompares, n_compared;
   // Released pins read back sclk, aux, inv and pol; only the serial out pin reads the inverse of its last value
   assign drv = {sclk, ~pout[3], aux, inv, pol};
   assign pin = (~poen & pout) | (poen & drv);
   adc_serial_result_port i_adc_serial_result_port (.CLK(clk), .RSTN(rstn),
      .RESULT_VALID(valid), .RESULT_DATA(data), .RESULT_READY(ready), .CONV_START(conv),
      .PORT_TYPE_SELECT(ser), .CLOCK_SOURCE_SELECT(csrc), .OUTPUT_CODING_SELECT(coding),
      .CHIP_SELECT_N(cs_n), .SHARED_PIN_IN(pin), .SHARED_PIN_OUT(pout),
      .SHARED_PIN_OEN(poen), .FRAME_SYNC(fsync));
   host_serial_model i_host (.clk(clk), .en(hen), .pol(pol), .inv(inv), .sdata(pout[3]),
      .mclk(pout[4]), .fsync(fsync), .sclk(sclk), .cs_n(cs_n));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) if (ready === 1'b0) saw_full = 1'b1;
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [RES_W-1:0] code(input logic [RES_W-1:0] v, input logic c);
      return c ? v : {~v[MSB], v[MSB-1:0]};
   endfunction
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (e !== g) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic summarize();
      if (miscompares == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic timed_out();
      miscompares++;
      summarize();
   endtask
   task automatic modes(input logic s, c, r, p, i);
      @(posedge clk);
      // Host capture only while master mode has settled
      hen <= 1'b0;
      ser <= s;
      csrc <= c;
      aux <= r;
      pol <= p;
      inv <= i;
      repeat (8) @(posedge clk);
      hen <= s & ~c;
   endtask
   // Holds valid across back-to-back words, drops it after the last
   task automatic push(input logic [RES_W-1:0] v, input logic last);
      int i;
      valid <= 1'b1;
      data <= v;
      exp_q.push_back(code(v, coding));
      for (i = 0; i < 3000; i++) begin
         @(posedge clk);
         if (ready === 1'b1) break;
      end
      if (i == 3000) timed_out();
      if (last) valid <= 1'b0;
   endtask
   task automatic check_frames(input int n);
      int i;
      for (i = 0; i < 3000 * n; i++) begin
         @(posedge clk);
         if (i_host.got_q.size() >= n) break;
      end
      if (i == 3000 * n) timed_out();
      repeat (n) chk("frame", exp_q.pop_front(), i_host.got_q.pop_front());
   endtask
   initial begin
      seed = 32'h000103BF;
      miscompares = 0;
      n_compared = 0;
      saw_full = 1'b0;
      hen = 1'b0;
      {rstn, valid, conv, ser, csrc, coding, pol, inv, aux} = '0;
      data = '0;
      repeat (20) @(posedge clk);
      chk("reset oen", OEN_OFF, poen);
      chk("reset sync", 0, fsync);
      chk("reset ready", 1, ready);
      rstn <= 1'b1;
      modes(0, 0, 0, 0, 0);
      for (int k = 0; k < 4; k++) begin
         coding <= k[0];
         w = RES_W'(xs());
         push(w, 1'b1);
         repeat (8) @(posedge clk);
         chk("parallel", 32'(code(w, k[0]) >> PAR_LO) & 32'h1F, 32'(pout));
         chk("parallel oen", OEN_PAR, poen);
      end
      exp_q.delete();
      coding <= 1'b1;
      modes(1, 0, 0, 0, 0);
      chk("master oen", OEN_MASTER, poen);
      chk("idle sync", 0, fsync);
      for (int k = 0; k < 10; k++) push(RES_W'(xs()), k == 9);
      check_frames(10);
      chk("fifo full", 1, saw_full);
      for (int k = 0; k < 4; k++) begin
         coding <= 1'(xs());
         modes(1, 0, 0, k[0], k[1]);
         chk("idle sync", k[0], fsync);
         push(RES_W'(xs()), 1'b1);
         check_frames(1);
      end
      modes(1, 0, 1, 0, 0);
      for (int k = 0; k < 2; k++) begin
         push(RES_W'(xs()), 1'b1);
         repeat (200) @(posedge clk);
         chk("no frame before start", 0, i_host.got_q.size());
         conv <= 1'b1;
         @(posedge clk);
         conv <= 1'b0;
         check_frames(1);
      end
      for (int k = 0; k < 2; k++) begin
         modes(1, 1, 0, 0, k[0]);
         chk("slave oen", OEN_SLAVE, poen);
         w = RES_W'(xs());
         push(w, 1'b1);
         void'(exp_q.pop_back());
         repeat (10) @(posedge clk);
         aux <= 1'(xs());
         @(posedge clk);
         #37;
         i_host.slave_read(17, k[0], bits);
         chk("slave", {15'h0, code(w, coding), aux}, bits);
      end
      chk("host checks", 0, i_host.bad);
      summarize();
   end
endmodule
